// ===== core/fic_cam_if.sv
// address table request and answer bundle
`timescale 1ns/1ps
interface fic_cam_if;
  logic                  op_valid;  // request strobe
  fic_pkg::fic_cam_op_e  op;        // request kind
  fic_pkg::fic_idx_t     idx;       // entry index
  logic                  vld;       // valid bit for set
  logic [47:0]           addr;      // address for set or compare
  logic                  rsp_valid; // answer strobe
  fic_pkg::fic_cam_op_e  rsp_op;    // kind answered
  logic                  rsp_hit;   // compare matched
  fic_pkg::fic_idx_t     rsp_idx;   // index answered
  logic                  rsp_vld;   // stored valid bit
  logic [47:0]           rsp_addr;  // stored address
  modport store (input op_valid, op, idx, vld, addr,
                 output rsp_valid, rsp_op, rsp_hit, rsp_idx, rsp_vld, rsp_addr);
  modport user (output op_valid, op, idx, vld, addr,
                input rsp_valid, rsp_op, rsp_hit, rsp_idx, rsp_vld, rsp_addr);
endinterface : fic_cam_if

// ===== core/fic_cam_table.sv
// address table store with set, read and compare
`timescale 1ns/1ps
`include "fic_cfg.svh"
module fic_cam_table (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  fic_cam_if.store cam  // requests and answers
);
  logic [47:0]               entry [`FIC_ENTRIES]; // stored addresses
  logic [`FIC_ENTRIES-1:0]   valid;                // per entry valid
  logic [`FIC_ENTRIES-1:0]   hit;                  // compare hits
  fic_pkg::fic_idx_t         next_idx;             // lowest hit

  // per entry store and compare; invalid entries never match
  for (genvar i = 0; i < `FIC_ENTRIES; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (rst) begin
        entry[i] <= 48'h0;
        valid[i] <= 1'b0;
      end else if (cam.op_valid && cam.op == fic_pkg::CAM_SET && cam.idx == 5'(i)) begin
        entry[i] <= cam.addr;
        valid[i] <= cam.vld;
      end
    end
    // full 48 bits compared, ig bit included
    assign hit[i] = valid[i] && entry[i] == cam.addr;
  end

  // lowest matching index wins
  always_comb begin
    next_idx = 5'h0;
    for (int k = `FIC_ENTRIES - 1; k >= 0; k--) begin
      if (hit[k]) begin
        next_idx = 5'(k);
      end
    end
  end

  // answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      cam.rsp_valid <= 1'b0;
      cam.rsp_op    <= fic_pkg::CAM_NONE;
      cam.rsp_hit   <= 1'b0;
      cam.rsp_idx   <= 5'h0;
      cam.rsp_vld   <= 1'b0;
      cam.rsp_addr  <= 48'h0;
    end else begin
      cam.rsp_valid <= cam.op_valid && cam.op != fic_pkg::CAM_SET;
      cam.rsp_op    <= cam.op;
      cam.rsp_hit   <= |hit;
      cam.rsp_idx   <= (cam.op == fic_pkg::CAM_CMP) ? ((|hit) ? next_idx : 5'h0) : cam.idx;
      cam.rsp_vld   <= valid[cam.idx];
      cam.rsp_addr  <= entry[cam.idx];
    end
  end

  a_cmp_hit: assert property (@(posedge clk) disable iff (rst)
    cam.op_valid && cam.op == fic_pkg::CAM_CMP |=> cam.rsp_valid && cam.rsp_hit == $past(|hit) &&
    (!cam.rsp_hit || (valid[cam.rsp_idx] && entry[cam.rsp_idx] == $past(cam.addr))))
    else $error("compare answer does not match table");
  c_cmp_hit: cover property (@(posedge clk) cam.rsp_valid && cam.rsp_op == fic_pkg::CAM_CMP && cam.rsp_hit);
endmodule : fic_cam_table

// ===== core/fic_cfg.svh
// constants for the receive indication and address table command codec
`ifndef FIC_CFG_SVH
`define FIC_CFG_SVH
// type field of each indication, bits 60..56 for five-bit codes (61..57 for compare), 61..56 for six-bit, 63..56 for eight-bit
`define FIC_T_PERR    5'h19
`define FIC_T_RXERR   5'h14
`define FIC_T_OWN     5'h1B
`define FIC_T_SDE     6'h3A
`define FIC_T_TOK     8'h3C
`define FIC_T_RDIND   6'h3B
`define FIC_T_CMPIND  5'h1E
// command codes, bits 61..56
`define FIC_C_SET     6'h39
`define FIC_C_RD      6'h3A
`define FIC_C_CMP     6'h3D
// port error field codes
`define FIC_PER_MAIN_ABORT 4'hC
`define FIC_PER_MAIN_PAR   4'hF
`define FIC_PER_MEM_ABORT  4'h4
`define FIC_PER_MEM_PAR    4'h7
`define FIC_PER_IDF_ABORT  4'h5
`define FIC_PER_IDF_PAR    4'h6
// source match field codes
`define FIC_SA_LOCAL  2'h3
`define FIC_SA_EXT    2'h2
`define FIC_SA_BRIDGE 2'h1
`define FIC_SA_ABORT  2'h0
// descriptor bit positions
`define FIC_B_CMD     63
`define FIC_B_VALID   55
`define FIC_B_IG      47
`define FIC_B_FC_RING 7
// register byte addresses
`define FIC_R_CTRL    8'h00
`define FIC_R_CMD_LO  8'h04
`define FIC_R_CMD_HI  8'h08
`define FIC_R_STATUS  8'h0C
`define FIC_R_LAST    8'h10
// control bits and reset value
`define FIC_CTRL_OWN  0
`define FIC_CTRL_TOK  1
`define FIC_CTRL_SPL  2
`define FIC_CTRL_RST  3'h0
`define FIC_ENTRIES   32
`endif

// ===== core/fic_perr_enc.sv
// port error field encoder
`timescale 1ns/1ps
`include "fic_cfg.svh"
module fic_perr_enc (
  input  fic_pkg::fic_psrc_e src,    // failing transfer path
  input  wire logic          parity, // parity fault, else abort
  output logic [3:0]         code    // port error field
);
  // parity outranks abort on the same path
  always_comb begin
    case (src)
      fic_pkg::PSRC_MAIN_OUT:   code = parity ? `FIC_PER_MAIN_PAR : `FIC_PER_MAIN_ABORT;
      fic_pkg::PSRC_IDF_TO_MEM: code = parity ? `FIC_PER_MEM_PAR : `FIC_PER_MEM_ABORT;
      fic_pkg::PSRC_TO_IDF:     code = parity ? `FIC_PER_IDF_PAR : `FIC_PER_IDF_ABORT;
      default:                  code = 4'h0;
    endcase
  end
endmodule : fic_perr_enc

// ===== core/fic_pkg.sv
// types shared by the codec modules
package fic_pkg;
  typedef enum logic [1:0] {CAM_NONE, CAM_SET, CAM_READ, CAM_CMP} fic_cam_op_e;
  typedef enum logic [1:0] {PSRC_MAIN_OUT, PSRC_IDF_TO_MEM, PSRC_TO_IDF, PSRC_NONE} fic_psrc_e;
  typedef logic [4:0] fic_idx_t;
endpackage : fic_pkg

// ===== core/fic_rx_ind_codec.sv
// receive indication builder and address table command decoder
//
// Summary of operation
// - port error indication, type bits 60..56
// - main fifo abort 1100, parity 1111
// - fifo to memory abort 0100, parity 0111
// - into fifo abort 0101, parity 0110
// - split flag set for split frame parts
// - first flag one for single buffer
// - split data discard gives all-zero error indication
// - every header indication gets one data indication
// - partly moved data gives normal error indication
// - own frame indication when enabled
// - frame control picks own frame ring
// - source match field two-bit encoding
// - token end indication needs a sent frame
// - unreturned frame count in bits 39..32
// - set stores address and valid bit
// - bit 47 is individual/group bit
// - read returns index, valid, address
// - compare reports match bit and index
// - miss clears match bit
`timescale 1ns/1ps
`include "fic_cfg.svh"
module fic_rx_ind_codec (
  input  wire logic        SYS_CLK,      // 20 MHz system clock
  input  wire logic        RESET,        // sync reset, high
  input  wire logic [7:0]  REG_ADDR,     // register byte address
  input  wire logic [31:0] REG_WDATA,    // register write data
  input  wire logic        REG_WR,       // write strobe
  input  wire logic        REG_RD,       // read strobe
  output logic      [31:0] REG_RDATA,    // read data, next cycle
  input  wire logic        CMD_VALID,    // ring command strobe
  input  wire logic [63:0] CMD_WORD,     // ring command word
  input  wire logic        PERR_VALID,   // port transfer failed
  input  wire logic [1:0]  PERR_SRC,     // failing path
  input  wire logic        PERR_PARITY,  // parity fault, else abort
  input  wire logic        FRM_SPLIT,    // frame is split
  input  wire logic        FRM_SINGLE,   // frame in one buffer
  input  wire logic [7:0]  FRM_STATUS,   // flag count and flags
  input  wire logic        DATA_DISCARD, // data part discarded
  input  wire logic        DATA_MOVED,   // some data already moved
  input  wire logic        OWN_FRAME,    // own frame stripped
  input  wire logic [7:0]  OWN_FC,       // its frame control byte
  input  wire logic [1:0]  OWN_SA,       // source match kind
  input  wire logic        TX_DONE,      // frame transmitted
  input  wire logic        OWN_BACK,     // sent frame came back
  input  wire logic        TOKEN_END,    // token cycle ended
  output logic             IND_VALID,    // indication strobe
  output logic             IND_RING,     // 0 first, 1 second rx ring
  output logic             IND_LOWER_WE, // lower half written too
  output logic      [63:0] IND_WORD      // indication word
);
  localparam int NSRC = 5; // cam, port error, data, own, token

  logic [2:0]        ctrl;          // enables
  logic [31:0]       cmd_lo;        // staged low command half
  logic [7:0]        tx_cnt;        // frames sent this cycle
  logic [7:0]        unret;         // sent, not yet back
  logic [31:0]       last_ind;      // last upper half sent
  logic [63:0]       cmd;           // command selected
  logic              cmd_go;        // command strobe
  logic [3:0]        perr_code;     // encoded port error
  logic              own_en;        // own frame enable
  logic              tok_en;        // token end enable
  logic              split_en;      // split mode enable
  logic              s_flag;        // split flag
  logic [NSRC-1:0]   ev;            // source events
  logic [63:0]       ev_word [NSRC];// words built now
  logic [NSRC-1:0]   ev_ring;       // ring per event
  logic [NSRC-1:0]   ev_lw;         // lower half per event
  logic [NSRC-1:0]   pend;          // waiting indications
  logic [63:0]       word_q [NSRC]; // held words
  logic [NSRC-1:0]   ring_q;        // held rings
  logic [NSRC-1:0]   lw_q;          // held lower flags
  logic [NSRC-1:0]   grant;         // one-hot winner
  logic [2:0]        sel;           // winner index
  logic [7:0]        next_tx;       // next sent count
  logic [7:0]        next_unret;    // next unreturned count

  fic_cam_if cam ();

  fic_cam_table u_cam (
    .clk (SYS_CLK),
    .rst (RESET),
    .cam (cam.store)
  );

  fic_perr_enc u_perr (
    .src    (fic_pkg::fic_psrc_e'(PERR_SRC)),
    .parity (PERR_PARITY),
    .code   (perr_code)
  );

  assign own_en   = ctrl[`FIC_CTRL_OWN];
  assign tok_en   = ctrl[`FIC_CTRL_TOK];
  assign split_en = ctrl[`FIC_CTRL_SPL];
  // split flag only in split mode
  assign s_flag   = FRM_SPLIT && split_en;

  // control register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl <= `FIC_CTRL_RST;
    end else if (REG_WR && REG_ADDR == `FIC_R_CTRL) begin
      ctrl <= REG_WDATA[2:0];
    end
  end

  // low command half waits for the high half
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cmd_lo <= 32'h0;
    end else if (REG_WR && REG_ADDR == `FIC_R_CMD_LO) begin
      cmd_lo <= REG_WDATA;
    end
  end

  // register read data, only in the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !REG_RD) begin
      REG_RDATA <= 32'h0;
    end else if (REG_ADDR == `FIC_R_CTRL) begin
      REG_RDATA <= {29'h0, ctrl};
    end else if (REG_ADDR == `FIC_R_CMD_LO) begin
      REG_RDATA <= cmd_lo;
    end else if (REG_ADDR == `FIC_R_STATUS) begin
      REG_RDATA <= {11'h0, pend, tx_cnt, unret};
    end else if (REG_ADDR == `FIC_R_LAST) begin
      REG_RDATA <= last_ind;
    end else begin
      REG_RDATA <= 32'h0; // unmapped reads as zero
    end
  end

  // register write of high half beats the ring source
  always_comb begin
    cmd_go = 1'b0;
    cmd    = CMD_WORD;
    if (REG_WR && REG_ADDR == `FIC_R_CMD_HI) begin
      cmd_go = 1'b1;
      cmd    = {REG_WDATA, cmd_lo};
    end else if (CMD_VALID) begin
      cmd_go = 1'b1;
    end
  end

  // command decode; unknown codes are dropped silently
  always_comb begin
    cam.op_valid = 1'b0;
    cam.op       = fic_pkg::CAM_NONE;
    cam.idx      = cmd[52:48];
    cam.vld      = cmd[`FIC_B_VALID];
    cam.addr     = cmd[47:0];
    // only words with bit 63 set are commands
    if (cmd_go && cmd[`FIC_B_CMD]) begin
      if (cmd[61:56] == `FIC_C_SET) begin
        cam.op_valid = 1'b1;
        cam.op       = fic_pkg::CAM_SET;
      end else if (cmd[61:56] == `FIC_C_RD) begin
        cam.op_valid = 1'b1;
        cam.op       = fic_pkg::CAM_READ;
      end else if (cmd[61:56] == `FIC_C_CMP && cmd[`FIC_B_VALID]) begin
        cam.op_valid = 1'b1;
        cam.op       = fic_pkg::CAM_CMP;
      end
    end
  end

  // indication words per source
  always_comb begin
    ev[0]      = cam.rsp_valid;
    ev_ring[0] = 1'b0;
    ev_lw[0]   = cam.rsp_op == fic_pkg::CAM_READ;
    if (cam.rsp_op == fic_pkg::CAM_READ) begin
      ev_word[0] = {2'b00, `FIC_T_RDIND, cam.rsp_vld, 2'b00, cam.rsp_idx, cam.rsp_addr};
    end else begin
      // match bit low on a miss
      ev_word[0] = {2'b00, `FIC_T_CMPIND, cam.rsp_hit, 3'b100, cam.rsp_idx, 48'h0};
    end
    ev[1]      = PERR_VALID;
    ev_ring[1] = 1'b0;
    ev_lw[1]   = 1'b0;
    ev_word[1] = {1'b0, s_flag, FRM_SINGLE, `FIC_T_PERR, FRM_STATUS, 12'h0, perr_code, 32'h0};
    // a discarded data part still answers its header
    ev[2]      = DATA_DISCARD;
    ev_ring[2] = 1'b0;
    ev_lw[2]   = 1'b0;
    if (split_en && !DATA_MOVED) begin
      ev_word[2] = {2'b00, `FIC_T_SDE, 56'h0};
    end else begin
      // moved data reports a normal error
      ev_word[2] = {1'b0, s_flag, FRM_SINGLE, `FIC_T_RXERR, FRM_STATUS, 48'h0};
    end
    // own frame gated by its enable
    ev[3]      = OWN_FRAME && own_en;
    ev_ring[3] = OWN_FC[`FIC_B_FC_RING];
    ev_lw[3]   = 1'b0;
    // source match kind passed as coded
    ev_word[3] = {3'b000, `FIC_T_OWN, FRM_STATUS, OWN_SA, 46'h0};
    // needs a frame sent this cycle
    ev[4]      = TOKEN_END && tok_en && tx_cnt != 8'h0;
    ev_ring[4] = 1'b0;
    ev_lw[4]   = 1'b0;
    ev_word[4] = {`FIC_T_TOK, 16'h0, unret, 32'h0};
  end

  // one held slot per source; a new event wins over its grant
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        pend[i]   <= 1'b0;
        word_q[i] <= 64'h0;
        ring_q[i] <= 1'b0;
        lw_q[i]   <= 1'b0;
      end else if (ev[i]) begin
        pend[i]   <= 1'b1;
        word_q[i] <= ev_word[i];
        ring_q[i] <= ev_ring[i];
        lw_q[i]   <= ev_lw[i];
      end else if (grant[i]) begin
        pend[i]   <= 1'b0;
      end
    end
  end

  // fixed priority, lowest source first; table answers never wait long
  always_comb begin
    grant = '0;
    sel   = 3'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (pend[k]) begin
        grant = NSRC'(1) << k;
        sel   = 3'(k);
      end
    end
  end

  // registered indication output
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      IND_VALID    <= 1'b0;
      IND_RING     <= 1'b0;
      IND_LOWER_WE <= 1'b0;
      IND_WORD     <= 64'h0;
    end else begin
      IND_VALID    <= |pend;
      IND_RING     <= ring_q[sel];
      // lower half kept except for table reads
      IND_LOWER_WE <= (|pend) && lw_q[sel];
      IND_WORD     <= word_q[sel];
    end
  end

  // last indication seen by software
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      last_ind <= 32'h0;
    end else if (|pend) begin
      last_ind <= word_q[sel][63:32];
    end
  end

  // token cycle counters, saturating both ways
  always_comb begin
    next_tx    = (TX_DONE && tx_cnt != 8'hFF) ? tx_cnt + 8'h01 : tx_cnt;
    next_unret = unret;
    if (TX_DONE && !OWN_BACK && unret != 8'hFF) begin
      next_unret = unret + 8'h01;
    end else if (OWN_BACK && !TX_DONE && unret != 8'h00) begin
      next_unret = unret - 8'h01;
    end
  end

  // counters restart at each token cycle end
  always_ff @(posedge SYS_CLK) begin
    if (RESET || TOKEN_END) begin
      tx_cnt <= 8'h0;
      unret  <= 8'h0;
    end else begin
      tx_cnt <= next_tx;
      unret  <= next_unret;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_perr_type: assert property (
    PERR_VALID && pend == '0 && !ev[0] |-> ##2 IND_VALID && IND_WORD[60:56] == `FIC_T_PERR)
    else $error("port error indication type wrong");
  a_perr_main: assert property (
    PERR_VALID && PERR_SRC == 2'h0 && PERR_PARITY && pend == '0 && !ev[0]
    |-> ##2 IND_WORD[35:32] == `FIC_PER_MAIN_PAR)
    else $error("main fifo parity code wrong");
  a_perr_mem: assert property (
    PERR_VALID && PERR_SRC == 2'h1 && !PERR_PARITY && pend == '0 && !ev[0]
    |-> ##2 IND_WORD[35:32] == `FIC_PER_MEM_ABORT)
    else $error("fifo to memory abort code wrong");
  a_perr_idf: assert property (
    PERR_VALID && PERR_SRC == 2'h2 && PERR_PARITY && pend == '0 && !ev[0]
    |-> ##2 IND_WORD[35:32] == `FIC_PER_IDF_PAR)
    else $error("into fifo parity code wrong");
  a_split_flag: assert property (
    PERR_VALID && pend == '0 && !ev[0] |-> ##2 IND_WORD[62] == $past(s_flag, 2))
    else $error("split flag wrong");
  a_first_flag: assert property (
    PERR_VALID && pend == '0 && !ev[0] |-> ##2 IND_WORD[61] == $past(FRM_SINGLE, 2))
    else $error("first flag wrong");
  a_sde_zero: assert property (
    DATA_DISCARD && split_en && !DATA_MOVED && pend == '0 && ev[1:0] == 2'b00
    |-> ##2 IND_VALID && IND_WORD == {2'b00, `FIC_T_SDE, 56'h0})
    else $error("split data error word wrong");
  a_moved_err: assert property (
    DATA_DISCARD && DATA_MOVED && pend == '0 && ev[1:0] == 2'b00
    |-> ##2 IND_WORD[60:56] == `FIC_T_RXERR)
    else $error("moved data not a normal error");
  a_own_ring: assert property (
    ev[3] && pend == '0 && ev[2:0] == 3'b000 |-> ##2 IND_RING == $past(OWN_FC[`FIC_B_FC_RING], 2))
    else $error("own frame ring wrong");
  a_tok_gate: assert property (
    TOKEN_END && tx_cnt == 8'h0 && !pend[4] |=> !pend[4])
    else $error("token end without sent frame");
  a_tok_count: assert property (
    ev[4] && pend == '0 && ev[3:0] == 4'h0 |-> ##2 IND_WORD[39:32] == $past(unret, 2))
    else $error("unreturned count wrong");
  a_cmd_bit: assert property (
    cam.op_valid |-> cmd[`FIC_B_CMD])
    else $error("indication word taken as command");

  c_perr: cover property (PERR_VALID ##2 IND_VALID);
  c_tok: cover property (ev[4] ##2 IND_VALID);
  c_read: cover property (cam.op_valid && cam.op == fic_pkg::CAM_READ ##3 IND_LOWER_WE);
endmodule : fic_rx_ind_codec

// ===== testbench/fic_ring_host.sv
// host model placing address table commands on the transmit ring
`timescale 1ns/1ps
module fic_ring_host (
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // sync reset, high
  input  wire logic        send,      // one command requested
  input  wire logic [63:0] word,      // command to place
  output logic             cmd_valid, // ring command strobe
  output logic      [63:0] cmd_word   // ring command word
);
  // ring delivery path
  // idle word toggles so a stale command never looks held
  always_ff @(posedge clk) begin
    cmd_valid <= rst ? 1'b0 : send;
    cmd_word  <= rst ? 64'h0 : (send ? word : ~cmd_word);
  end
endmodule : fic_ring_host

// ===== testbench/rx_indication_cam_cmd_codec_tb.sv
// self-checking bench for the indication builder and table commands
`timescale 1ns/1ps
`include "fic_cfg.svh"
module rx_indication_cam_cmd_codec_tb;
  logic        SYS_CLK = 0, RESET = 1;  // clock and reset
  logic [7:0]  REG_ADDR = 0;            // register address
  logic [31:0] REG_WDATA = 0, REG_RDATA; // register data
  logic        REG_WR = 0, REG_RD = 0;  // register strobes
  logic        CMD_VALID, send = 0;     // ring strobe and request
  logic [63:0] CMD_WORD, word = 0, IND_WORD; // command and indication
  logic [1:0]  PERR_SRC = 0, OWN_SA = 0; // path and match kind
  logic        PERR_PARITY = 0, FRM_SPLIT = 0, FRM_SINGLE = 0; // context
  logic [7:0]  FRM_STATUS = 8'hB4, OWN_FC = 0; // status and frame control
  logic        DATA_MOVED = 0;          // data partly moved
  logic [5:0]  ev = 0;                  // event pulses
  logic        IND_VALID, IND_RING, IND_LOWER_WE; // indication outputs
  logic [31:0] rd;                      // read result
  int          err_total = 0, samples_checked = 0, cyc = 0; // counters
  logic [3:0]  pe_code [8] = '{4'hC, 4'hF, 4'h4, 4'h7, 4'h5, 4'h6, 4'h0, 4'h0}; // codes
  logic [47:0] a5 = 48'h8000_1234_5678, a9 = 48'h0000_ABCD_EF01; // entries

  fic_rx_ind_codec fic_rx_ind_codec_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD), .PERR_VALID(ev[0]), .PERR_SRC(PERR_SRC),
    .PERR_PARITY(PERR_PARITY), .FRM_SPLIT(FRM_SPLIT), .FRM_SINGLE(FRM_SINGLE),
    .FRM_STATUS(FRM_STATUS), .DATA_DISCARD(ev[1]), .DATA_MOVED(DATA_MOVED), .OWN_FRAME(ev[2]),
    .OWN_FC(OWN_FC), .OWN_SA(OWN_SA), .TX_DONE(ev[3]), .OWN_BACK(ev[4]), .TOKEN_END(ev[5]),
    .IND_VALID(IND_VALID), .IND_RING(IND_RING), .IND_LOWER_WE(IND_LOWER_WE), .IND_WORD(IND_WORD));
  fic_ring_host fic_ring_host_inst (.clk(SYS_CLK), .rst(RESET), .send(send), .word(word),
    .cmd_valid(CMD_VALID), .cmd_word(CMD_WORD));

  // 50 ns clock
  initial begin
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  // hang guard, tests need well under a thousand cycles
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1; REG_ADDR <= a; REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 0;
  endtask : reg_wr
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    REG_RD <= 1; REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 0;
    #1 d = REG_RDATA;
  endtask : reg_rd
  task automatic fire(input int b);
    @(posedge SYS_CLK);
    ev <= 6'h01 << b;
    @(posedge SYS_CLK);
    ev <= 6'h00;
  endtask : fire
  task automatic ring(input logic [63:0] w);
    @(posedge SYS_CLK);
    send <= 1; word <= w;
    @(posedge SYS_CLK);
    send <= 0;
  endtask : ring
  task automatic host_cmd(input logic [63:0] w);
    reg_wr(`FIC_R_CMD_LO, w[31:0]);
    reg_wr(`FIC_R_CMD_HI, w[63:32]);
  endtask : host_cmd
  // wait for one indication, then check word, strobe, ring and lower-half flag
  task automatic ind(input string nm, input logic [63:0] exp, input logic [1:0] side);
    int k;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      #1 k++;
    end while (k < 20 && IND_VALID !== 1'b1);
    chk(nm, exp, IND_WORD);
    chk(nm, {61'h0, 1'b1, side}, {61'h0, IND_VALID, IND_RING, IND_LOWER_WE});
  endtask : ind
  task automatic none(input string nm);
    repeat (8) begin
      @(posedge SYS_CLK);
      #1 chk(nm, 64'h0, {63'h0, IND_VALID});
    end
  endtask : none

  initial begin
    repeat (6) @(posedge SYS_CLK);
    RESET <= 0;
    reg_rd(`FIC_R_CTRL, rd);
    chk("ctrl reset", 64'h0, {32'h0, rd});
    reg_rd(8'h14, rd);
    chk("unmapped read", 64'h0, {32'h0, rd});
    reg_wr(`FIC_R_CTRL, 32'h4);
    // port error codes for every path and fault kind
    for (int i = 0; i < 8; i++) begin
      @(posedge SYS_CLK);
      PERR_SRC <= i / 2; PERR_PARITY <= i % 2; FRM_SPLIT <= (i < 3); FRM_SINGLE <= i % 2;
      fire(0);
      ind("port error", {1'b0, i < 3, i % 2 == 1, 5'b11001, 8'hB4, 12'h0, pe_code[i], 32'h0}, 2'b00);
    end
    @(posedge SYS_CLK);
    FRM_SPLIT <= 1; FRM_SINGLE <= 0; DATA_MOVED <= 0;
    fire(1);
    ind("split discard", {8'h3A, 56'h0}, 2'b00);
    @(posedge SYS_CLK);
    DATA_MOVED <= 1;
    fire(1);
    ind("moved discard", {1'b0, 1'b1, 1'b0, 5'b10100, 8'hB4, 48'h0}, 2'b00);
    fire(2);
    none("own frame disabled");
    fire(3);
    fire(5);
    none("token end disabled");
    reg_wr(`FIC_R_CTRL, 32'h7);
    fire(5);
    none("token end idle cycle");
    // every source match code, frame control picks the ring
    for (int i = 0; i < 4; i++) begin
      @(posedge SYS_CLK);
      OWN_SA <= i; OWN_FC <= {i[0], 7'h15};
      fire(2);
      ind("own frame", {3'b000, 5'b11011, 8'hB4, 2'(i), 46'h0}, {i[0], 1'b0});
    end
    repeat (3) fire(3);
    fire(4);
    reg_rd(`FIC_R_STATUS, rd);
    chk("status counts", 64'h0302, {32'h0, rd});
    fire(5);
    ind("token end", {8'h3C, 16'h0, 8'd2, 32'h0}, 2'b00);
    // table set by register and by ring, an invalid twin at index 2
    host_cmd({2'b10, 6'h39, 1'b1, 2'b00, 5'd5, a5});
    host_cmd({2'b10, 6'h39, 1'b0, 2'b00, 5'd2, a5});
    ring({2'b11, 6'h39, 1'b1, 2'b00, 5'd9, a9});
    none("set gives no indication");
    host_cmd({2'b10, 6'h3A, 3'b000, 5'd5, 48'h0});
    ind("read valid", {2'b00, 6'h3B, 1'b1, 2'b00, 5'd5, a5}, 2'b01);
    ring({2'b10, 6'h3A, 3'b000, 5'd2, 48'h0});
    ind("read invalid", {2'b00, 6'h3B, 1'b0, 2'b00, 5'd2, a5}, 2'b01);
    host_cmd({2'b10, 6'h3D, 1'b1, 7'h0, a5});
    ind("compare hit", {2'b00, 5'b11110, 1'b1, 1'b1, 2'b00, 5'd5, 48'h0}, 2'b00);
    ring({2'b10, 6'h3D, 1'b1, 7'h0, a9});
    ind("compare ring hit", {2'b00, 5'b11110, 1'b1, 1'b1, 2'b00, 5'd9, 48'h0}, 2'b00);
    host_cmd({2'b10, 6'h3D, 1'b1, 7'h0, a5 ^ 48'h8000_0000_0000});
    ind("compare miss", {2'b00, 5'b11110, 1'b0, 1'b1, 7'h0, 48'h0}, 2'b00);
    reg_rd(`FIC_R_LAST, rd);
    chk("last upper half", 64'h3C80_0000, {32'h0, rd});
    host_cmd({2'b10, 6'h3D, 1'b0, 7'h0, a5});
    ring({2'b00, 6'h3A, 3'b000, 5'd5, 48'h0});
    none("bit 63 clear ignored");
    results();
  end
endmodule : rx_indication_cam_cmd_codec_tb
